// [mtic_csr.v]
// Machine interrupt pending/enable, delegation and trap entry registers.
`timescale 1ns/1ps
`include "mtic_map.vh"
module mtic_csr #(
  parameter HAS_S = 1,
  parameter HAS_U = 1
)(
  input  wire        mclk,
  input  wire        rst_n,
  input  wire [1:0]  cur_priv,
  input  wire        machine_ie,
  input  wire        sup_ie,
  input  wire        user_ie,
  input  wire        csr_we,
  input  wire [11:0] csr_addr,
  input  wire [31:0] csr_wdata,
  output reg  [31:0] csr_rdata,
  output wire        csr_hit,
  input  wire        machine_timer_pending,
  input  wire        machine_soft_pending,
  input  wire        machine_ext_pending,
  input  wire        exc_valid,
  input  wire [3:0]  exc_code,
  input  wire [31:0] trap_pc,
  input  wire        nmi_req,
  output wire        irq_take,
  output wire [3:0]  irq_code,
  output wire [1:0]  irq_target,
  output reg         trap_entry,
  output reg  [31:0] trap_next_pc
);
  // Bits of levels the core lacks are masked out everywhere.
  localparam [31:0] LVL_MASK = `MTIC_IRQ_ALL
    & ~(HAS_S ? 32'h00000000 : `MTIC_S_BITS)
    & ~(HAS_U ? 32'h00000000 : `MTIC_U_BITS);

  reg  [31:0] ip_soft;
  reg  [31:0] interrupt_enable;
  reg  [31:0] ideleg;
  reg  [31:0] nmi_vector;
  reg  [31:0] trap_scratch;
  reg  [31:0] trap_return_pc;
  reg         cause_irq;
  reg  [3:0]  cause_code;

  // Raw levels from the far side: timer, soft, then external.
  wire [2:0]  hw_raw;
  wire [2:0]  hw_pend;
  wire [31:0] interrupt_pending;
  wire [31:0] hw_bits;
  wire [31:0] s_view;
  wire [31:0] u_view;
  wire [31:0] ready;
  wire [31:0] to_m;
  wire [31:0] to_s;
  wire [31:0] to_u;
  wire        gm;
  wire        gs;
  wire        gu;
  wire [31:0] cand;
  wire [31:0] cand_m;
  wire [31:0] cand_s;
  wire [31:0] cand_u;
  wire [31:0] u_bits;
  wire [31:0] sip_rd;
  wire [31:0] sie_rd;
  wire [31:0] uip_rd;
  wire [31:0] uie_rd;
  reg  [1:0]  tgt;
  reg         hit;
  genvar      g;

  assign hw_raw = {machine_ext_pending, machine_soft_pending,
                   machine_timer_pending};

  // The far-side levels are asynchronous, so each passes three stages.
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_sync
      reg [2:0] stage;
      reg       level;
      always @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stage <= 3'h0;
          level <= 1'b0;
        end
        else
        begin
          stage <= {stage[1:0], hw_raw[g]};
          // A change is accepted once stages two and three agree.
          if (stage[2] == stage[1])
            level <= stage[2];
        end
      end
      assign hw_pend[g] = level;
    end
  endgenerate

  // Hardware-owned bits sit at the machine positions only.
  assign hw_bits = ({31'h0, hw_pend[0]} << `MTIC_BIT_MTI)
                 | ({31'h0, hw_pend[1]} << `MTIC_BIT_MSI)
                 | ({31'h0, hw_pend[2]} << `MTIC_BIT_MEI);

  // Reserved positions and levels the core lacks read as zero.
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : g_pend
      assign interrupt_pending[g] = LVL_MASK[g]
                                  & (hw_bits[g] | ip_soft[g]);
    end
  endgenerate
  // Lower views never see machine bits, which cannot be delegated.
  assign s_view = ideleg & `MTIC_S_BITS;
  assign u_view = ideleg & `MTIC_U_BITS;

  // Writes from user level to the supervisor views are dropped; the
  // user views are open to every level.
  wire wr_ip   = csr_we && (csr_addr == `MTIC_CSR_IP);
  wire wr_sip  = csr_we && (csr_addr == `MTIC_CSR_SIP)
                 && (cur_priv != `MTIC_PRV_U);
  wire wr_uip  = csr_we && (csr_addr == `MTIC_CSR_UIP);
  wire wr_ie   = csr_we && (csr_addr == `MTIC_CSR_IE);
  wire wr_sie  = csr_we && (csr_addr == `MTIC_CSR_SIE)
                 && (cur_priv != `MTIC_PRV_U);
  wire wr_uie  = csr_we && (csr_addr == `MTIC_CSR_UIE);
  wire wr_ideleg = csr_we && (csr_addr == `MTIC_CSR_IDELEG);

  // Lower-mode views write only their software pending bit.
  wire [31:0] sip_wmask = s_view & 32'h00000003;
  wire [31:0] uip_wmask = u_view & 32'h00000001;

  // Machine writes replace all writable bits; views merge by mask.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ip_soft <= `MTIC_RST_WORD;
    else if (wr_ip)
      ip_soft <= csr_wdata & `MTIC_IP_MWR & LVL_MASK;
    else if (wr_sip)
      ip_soft <= (ip_soft & ~sip_wmask)
               | (csr_wdata & sip_wmask & LVL_MASK);
    else if (wr_uip)
      ip_soft <= (ip_soft & ~uip_wmask)
               | (csr_wdata & uip_wmask & LVL_MASK);
  end

  // Lower-mode enable writes touch delegated bits only.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      interrupt_enable <= `MTIC_RST_WORD;
    else if (wr_ie)
      interrupt_enable <= csr_wdata & LVL_MASK;
    else if (wr_sie)
      interrupt_enable <= (interrupt_enable & ~s_view)
                        | (csr_wdata & s_view & LVL_MASK);
    else if (wr_uie)
      interrupt_enable <= (interrupt_enable & ~u_view)
                        | (csr_wdata & u_view & LVL_MASK);
  end

  // Machine-level bits cannot be handed down, so they never stick.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ideleg <= `MTIC_RST_WORD;
    else if (wr_ideleg)
      ideleg <= csr_wdata & LVL_MASK & ~`MTIC_M_BITS;
  end

  // A bit is a candidate only with its enable and its global enable.
  assign ready = interrupt_pending & interrupt_enable;
  assign to_m  = ready & ~ideleg;
  assign to_s  = ready & ideleg & `MTIC_S_BITS;
  assign to_u  = ready & ideleg & `MTIC_U_BITS;
  assign gm = (cur_priv != `MTIC_PRV_M) || machine_ie;
  assign gs = (cur_priv == `MTIC_PRV_U) ||
              (cur_priv == `MTIC_PRV_S && sup_ie);
  assign gu = (cur_priv == `MTIC_PRV_U) && user_ie;
  // Each level's global enable gates only its own candidates.
  assign cand_m = gm ? to_m : 32'h00000000;
  assign cand_s = gs ? to_s : 32'h00000000;
  assign cand_u = gu ? to_u : 32'h00000000;
  assign cand   = cand_m | cand_s | cand_u;

  // Fixed order: external, software, timer; machine first in class.
  reg [3:0] sel;
  reg       sel_v;
  always @*
  begin
    sel_v = 1'b1;
    if      (cand[`MTIC_BIT_MEI]) sel = 4'hB;
    else if (cand[`MTIC_BIT_SEI]) sel = 4'h9;
    else if (cand[`MTIC_BIT_UEI]) sel = 4'h8;
    else if (cand[`MTIC_BIT_MSI]) sel = 4'h3;
    else if (cand[`MTIC_BIT_SSI]) sel = 4'h1;
    else if (cand[`MTIC_BIT_USI]) sel = 4'h0;
    else if (cand[`MTIC_BIT_MTI]) sel = 4'h7;
    else if (cand[`MTIC_BIT_STI]) sel = 4'h5;
    else if (cand[`MTIC_BIT_UTI]) sel = 4'h4;
    else
    begin
      sel   = 4'h0;
      sel_v = 1'b0;
    end
  end

  assign irq_take   = sel_v;
  assign irq_code   = sel;
  assign u_bits = `MTIC_U_BITS;

  // Delegated bits go to supervisor unless they are user-level ones.
  always @*
  begin
    if (!ideleg[sel])
      tgt = `MTIC_PRV_M;
    else if (u_bits[sel])
      tgt = `MTIC_PRV_U;
    else
      tgt = `MTIC_PRV_S;
  end
  assign irq_target = tgt;

  // An interrupt taken to machine level beats a synchronous trap.
  wire m_irq = sel_v && (irq_target == `MTIC_PRV_M);
  wire wr_m  = csr_we && csr_addr[11:8] == 4'h3;
  // The vector sits outside the 0x3xx window, so it decodes on its own.
  wire wr_nmivec  = csr_we && (csr_addr == `MTIC_CSR_NMIVEC);
  wire wr_scratch = wr_m && (csr_addr == `MTIC_CSR_SCRATCH);
  wire wr_epc     = wr_m && (csr_addr == `MTIC_CSR_EPC);
  wire wr_cause   = wr_m && (csr_addr == `MTIC_CSR_CAUSE);
  wire m_trap     = m_irq || exc_valid;
  wire any_trap   = nmi_req || m_trap;
  wire [3:0] next_code = m_irq ? sel : exc_code;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      nmi_vector <= `MTIC_RST_WORD;
    else if (wr_nmivec)
      nmi_vector <= csr_wdata;
  end

  // Hardware never writes the scratch word.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      trap_scratch <= `MTIC_RST_WORD;
    else if (wr_scratch)
      trap_scratch <= csr_wdata;
  end

  // A trap entry beats a software write in the same cycle.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      trap_return_pc <= `MTIC_RST_WORD;
    else if (any_trap)
      trap_return_pc <= {trap_pc[31:2], 2'h0};
    else if (wr_epc)
      trap_return_pc <= {csr_wdata[31:2], 2'h0};
  end

  // The cause keeps its last value across a non-maskable entry, so a
  // handler can still see why the interrupted trap was taken.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cause_irq  <= 1'b0;
      cause_code <= 4'h0;
    end
    else if (!nmi_req && m_trap)
    begin
      cause_irq  <= m_irq;
      cause_code <= next_code;
    end
    else if (wr_cause)
    begin
      cause_irq  <= csr_wdata[31];
      cause_code <= csr_wdata[3:0];
    end
  end

  // Machine traps load the same vector; no mode field is kept here.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trap_entry   <= 1'b0;
      trap_next_pc <= `MTIC_RST_WORD;
    end
    else
    begin
      trap_entry <= any_trap;
      if (any_trap)
        trap_next_pc <= nmi_vector;
    end
  end

  always @*
  begin
    case (csr_addr)
      `MTIC_CSR_IP:      hit = 1'b1;
      `MTIC_CSR_IE:      hit = 1'b1;
      `MTIC_CSR_IDELEG:  hit = 1'b1;
      `MTIC_CSR_NMIVEC:  hit = 1'b1;
      `MTIC_CSR_SCRATCH: hit = 1'b1;
      `MTIC_CSR_EPC:     hit = 1'b1;
      `MTIC_CSR_CAUSE:   hit = 1'b1;
      `MTIC_CSR_SIP:     hit = 1'b1;
      `MTIC_CSR_SIE:     hit = 1'b1;
      `MTIC_CSR_UIP:     hit = 1'b1;
      `MTIC_CSR_UIE:     hit = 1'b1;
      default:           hit = 1'b0;
    endcase
  end
  assign csr_hit = hit;

  // Read data is combinational so it is seen in the access cycle.
  assign sip_rd = interrupt_pending & s_view;
  assign sie_rd = interrupt_enable & s_view;
  assign uip_rd = interrupt_pending & u_view;
  assign uie_rd = interrupt_enable & u_view;

  always @*
  begin
    case (csr_addr)
      `MTIC_CSR_IP:      csr_rdata = interrupt_pending;
      `MTIC_CSR_IE:      csr_rdata = interrupt_enable;
      `MTIC_CSR_IDELEG:  csr_rdata = ideleg;
      `MTIC_CSR_NMIVEC:  csr_rdata = nmi_vector;
      `MTIC_CSR_SCRATCH: csr_rdata = trap_scratch;
      `MTIC_CSR_EPC:     csr_rdata = trap_return_pc;
      `MTIC_CSR_CAUSE:   csr_rdata = {cause_irq, 27'h0, cause_code};
      `MTIC_CSR_SIP:     csr_rdata = sip_rd;
      `MTIC_CSR_SIE:     csr_rdata = sie_rd;
      `MTIC_CSR_UIP:     csr_rdata = uip_rd;
      `MTIC_CSR_UIE:     csr_rdata = uie_rd;
      default:           csr_rdata = 32'h00000000;
    endcase
  end
endmodule

// [mtic_map.vh]
// Register addresses, field positions, reset values and privilege-level codes.
`ifndef MTIC_MAP_VH
`define MTIC_MAP_VH
`define MTIC_CSR_IP        12'h344
`define MTIC_CSR_IE        12'h304
`define MTIC_CSR_IDELEG    12'h303
`define MTIC_CSR_NMIVEC    12'h7C0
`define MTIC_CSR_SCRATCH   12'h340
`define MTIC_CSR_EPC       12'h341
`define MTIC_CSR_CAUSE     12'h342
`define MTIC_CSR_SIP       12'h144
`define MTIC_CSR_SIE       12'h104
`define MTIC_CSR_UIP       12'h044
`define MTIC_CSR_UIE       12'h004
`define MTIC_BIT_USI       0
`define MTIC_BIT_SSI       1
`define MTIC_BIT_MSI       3
`define MTIC_BIT_UTI       4
`define MTIC_BIT_STI       5
`define MTIC_BIT_MTI       7
`define MTIC_BIT_UEI       8
`define MTIC_BIT_SEI       9
`define MTIC_BIT_MEI       11
`define MTIC_IRQ_ALL       32'h00000BBB
`define MTIC_IP_MWR        32'h00000333
`define MTIC_U_BITS        32'h00000111
`define MTIC_S_BITS        32'h00000222
`define MTIC_M_BITS        32'h00000888
`define MTIC_RST_WORD      32'h00000000
`define MTIC_PRV_U         2'h0
`define MTIC_PRV_S         2'h1
`define MTIC_PRV_M         2'h3
`endif

// [mtic_far.sv]
// Far-side model: machine timer, remote-hart soft register, irq controller.
`timescale 1ns/1ps
module mtic_far (
  input  logic mclk,
  input  logic fire,
  input  logic cmp_wr,
  input  logic soft_wr,
  input  logic soft_val,
  input  logic ext_lvl,
  output logic machine_timer_pending,
  output logic machine_soft_pending,
  output logic machine_ext_pending
);
  initial
  begin
    machine_timer_pending = 1'h0;
    machine_soft_pending = 1'h0;
  end
  // A compare write wins over a same-cycle expiry, as on the real timer.
  always @(posedge mclk)
  begin
    if (cmp_wr)
      machine_timer_pending <= 1'h0;
    else if (fire)
      machine_timer_pending <= 1'h1;
    if (soft_wr)
      machine_soft_pending <= soft_val;
  end
  assign machine_ext_pending = ext_lvl;
endmodule

// [mtic_csr_properties.sv]
// Concurrent checks on the interrupt and trap CSR block ports.
`timescale 1ns/1ps
`include "mtic_map.vh"
module mtic_props (
  input logic        mclk,
  input logic        rst_n,
  input logic [1:0]  cur_priv,
  input logic        machine_ie,
  input logic        sup_ie,
  input logic [11:0] csr_addr,
  input logic [31:0] csr_rdata,
  input logic        machine_ext_pending,
  input logic        exc_valid,
  input logic        nmi_req,
  input logic        irq_take,
  input logic [3:0]  irq_code,
  input logic [1:0]  irq_target,
  input logic        trap_entry
);
  localparam logic [31:0] irq_all = `MTIC_IRQ_ALL;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_exc_entry: assert property (exc_valid |=> trap_entry)
    else $error("no trap entry after exception");
  a_nmi_entry: assert property (nmi_req |=> trap_entry)
    else $error("no trap entry after nmi");
  a_irq_entry: assert property (
    irq_take && irq_target == `MTIC_PRV_M |=> trap_entry)
    else $error("no trap entry after interrupt");
  a_epc_low_zero: assert property (
    csr_addr == `MTIC_CSR_EPC |-> csr_rdata[1:0] == 2'h0)
    else $error("return pc low bits set");
  a_code_legal: assert property (irq_take |-> irq_all[irq_code])
    else $error("reserved interrupt code");
  a_m_global: assert property (irq_take && irq_target == `MTIC_PRV_M
    |-> cur_priv != `MTIC_PRV_M || machine_ie)
    else $error("machine interrupt taken while disabled");
  a_s_global: assert property (irq_take && irq_target == `MTIC_PRV_S
    |-> cur_priv == `MTIC_PRV_U || cur_priv == `MTIC_PRV_S && sup_ie)
    else $error("supervisor interrupt taken while disabled");
  a_ext_follows: assert property (
    $stable(machine_ext_pending)[*6] ##0 csr_addr == `MTIC_CSR_IP
    |-> csr_rdata[11] == machine_ext_pending)
    else $error("external pending bit does not follow line");
  c_sup_irq: cover property (irq_take && irq_target == `MTIC_PRV_S);
  c_nmi: cover property (nmi_req ##1 trap_entry);
  c_exc: cover property (exc_valid ##1 trap_entry);
endmodule
bind mtic_csr mtic_props i_mtic_props (.mclk, .rst_n, .cur_priv,
  .machine_ie, .sup_ie, .csr_addr, .csr_rdata, .machine_ext_pending,
  .exc_valid, .nmi_req, .irq_take, .irq_code, .irq_target, .trap_entry);

// [mtic_csr_bench.sv]
// Self-checking bench for the interrupt and trap CSR block.
`timescale 1ns/1ps
`include "mtic_map.vh"
module mtic_csr_bench;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d, e;} mtic_row;
  logic        mclk, rst_n, machine_ie, sup_ie, csr_we, exc_valid, nmi_req;
  logic        fire, cmp_wr, soft_wr, soft_val, ext_lvl, irq_take, trap_entry;
  logic        user_ie, csr_hit;
  logic        machine_timer_pending, machine_soft_pending, machine_ext_pending;
  logic [1:0]  cur_priv, irq_target;
  logic [3:0]  exc_code, irq_code;
  logic [11:0] csr_addr;
  logic [31:0] csr_wdata, csr_rdata, trap_pc, trap_next_pc;
  int          fails, check_count;
  mtic_row     rows[12] = '{
    '{1'h1, `MTIC_CSR_IE, 32'hFFFFFFFF, 32'h00000BBB},
    '{1'h1, `MTIC_CSR_IDELEG, 32'hFFFFFFFF, 32'h00000333},
    '{1'h1, `MTIC_CSR_IP, 32'hFFFFFFFF, 32'h00000333},
    '{1'h0, `MTIC_CSR_SIP, 32'h0, 32'h00000222},
    '{1'h0, `MTIC_CSR_UIP, 32'h0, 32'h00000111},
    '{1'h1, `MTIC_CSR_IDELEG, 32'h0, 32'h0},
    '{1'h0, `MTIC_CSR_SIP, 32'h0, 32'h0},
    '{1'h1, `MTIC_CSR_SCRATCH, 32'hA5A5A5A5, 32'hA5A5A5A5},
    '{1'h1, `MTIC_CSR_EPC, 32'h12345677, 32'h12345674},
    '{1'h1, `MTIC_CSR_NMIVEC, 32'h80000004, 32'h80000004},
    '{1'h1, 12'h7FF, 32'hFFFFFFFF, 32'h0},
    '{1'h1, `MTIC_CSR_IP, 32'h0, 32'h0}};
  mtic_csr i_mtic_csr (.mclk, .rst_n, .cur_priv, .machine_ie, .sup_ie,
    .user_ie, .csr_we, .csr_addr, .csr_wdata, .csr_rdata, .csr_hit,
    .machine_timer_pending, .machine_soft_pending, .machine_ext_pending,
    .exc_valid, .exc_code, .trap_pc, .nmi_req, .irq_take, .irq_code,
    .irq_target, .trap_entry, .trap_next_pc);
  mtic_far i_mtic_far (.mclk, .fire, .cmp_wr, .soft_wr, .soft_val, .ext_lvl,
    .machine_timer_pending, .machine_soft_pending, .machine_ext_pending);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge mclk);
    {csr_we, csr_addr, csr_wdata} = {1'h1, a, d};
    @(negedge mclk);
    csr_we = 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(negedge mclk);
    csr_addr = a;
    #1 chk(csr_rdata, e);
  endtask
  // Packs take, target and code so one compare covers the whole decision.
  task automatic irq(input logic [31:0] e);
    @(negedge mclk);
    #1 chk({25'h0, irq_take, irq_target, irq_code}, e);
  endtask
  task report_and_stop;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    repeat (2000) @(posedge mclk);
    fails++;
    report_and_stop;
  end
  initial
  begin
    {rst_n, machine_ie, sup_ie, user_ie, csr_we, exc_valid, nmi_req} = 7'h00;
    {fire, cmp_wr, soft_wr, soft_val, ext_lvl} = 5'h00;
    {cur_priv, exc_code, csr_addr, csr_wdata} = {2'h3, 4'h0, 12'h0, 32'h0};
    trap_pc = 32'h00001000;
    fails = 0;
    check_count = 0;
    repeat (20) @(negedge mclk);
    rst_n = 1'h1;
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    $display("table done");
    chk({31'h0, csr_hit}, 32'h1);
    csr_addr = 12'h7FF;
    #1 chk({31'h0, csr_hit}, 32'h0);
    {ext_lvl, fire, soft_wr, soft_val} = 4'hF;
    wr(`MTIC_CSR_IP, 32'h00000020);
    {fire, soft_wr} = 2'h0;
    repeat (6) @(negedge mclk);
    rd(`MTIC_CSR_IP, 32'h000008A8);
    machine_ie = 1'h1;
    irq(32'h7B);
    rd(`MTIC_CSR_CAUSE, 32'h8000000B);
    rd(`MTIC_CSR_EPC, 32'h00001000);
    ext_lvl = 1'h0;
    repeat (6) @(negedge mclk);
    irq(32'h73);
    {soft_wr, soft_val} = 2'h2;
    @(negedge mclk);
    soft_wr = 1'h0;
    repeat (6) @(negedge mclk);
    irq(32'h77);
    cmp_wr = 1'h1;
    @(negedge mclk);
    cmp_wr = 1'h0;
    repeat (6) @(negedge mclk);
    irq(32'h75);
    machine_ie = 1'h0;
    #1 chk({31'h0, irq_take}, 32'h0);
    cur_priv = `MTIC_PRV_S;
    irq(32'h75);
    $display("priority done");
    cur_priv = `MTIC_PRV_M;
    wr(`MTIC_CSR_IP, 32'h0);
    wr(`MTIC_CSR_IDELEG, 32'h00000002);
    cur_priv = `MTIC_PRV_S;
    wr(`MTIC_CSR_SIP, 32'hFFFFFFFF);
    rd(`MTIC_CSR_IP, 32'h00000002);
    #1 chk({31'h0, irq_take}, 32'h0);
    cur_priv = `MTIC_PRV_U;
    irq(32'h51);
    cur_priv = `MTIC_PRV_M;
    wr(`MTIC_CSR_IDELEG, 32'h00000001);
    wr(`MTIC_CSR_IP, 32'h00000001);
    cur_priv = `MTIC_PRV_U;
    user_ie = 1'h1;
    irq(32'h40);
    cur_priv = `MTIC_PRV_M;
    wr(`MTIC_CSR_IP, 32'h0);
    exc_code = 4'h2;
    exc_valid = 1'h1;
    @(negedge mclk);
    exc_valid = 1'h0;
    rd(`MTIC_CSR_CAUSE, 32'h00000002);
    nmi_req = 1'h1;
    @(negedge mclk);
    nmi_req = 1'h0;
    #1 chk({31'h0, trap_entry}, 32'h1);
    chk(trap_next_pc, 32'h80000004);
    $display("traps done");
    rst_n = 1'h0;
    @(negedge mclk);
    rst_n = 1'h1;
    rd(`MTIC_CSR_NMIVEC, 32'h0);
    rd(`MTIC_CSR_SCRATCH, 32'h0);
    $display("reset done");
    report_and_stop;
  end
endmodule
